// ### hw/sdep_device.sv
// device end: serial command decode, core registers and data memory
`timescale 1ns/1ps
module sdep_device
	import sdep_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	sdep_icsp_if.dev link,
	output logic writeBusy
);
	typedef enum logic [2:0] {D_IDLE = 3'b001, D_ARMED = 3'b010, D_WRITING = 3'b100} sdep_dst_t;
	sdep_dst_t state_reg;
	logic [1:0] clkSync_reg, datSync_reg;
	logic pgcPrev_reg;
	logic [4:0] bitCnt_reg;
	logic [3:0] cmd_reg;
	logic [15:0] pay_reg;
	logic [7:0] addrLow_reg, addrHigh_reg, data_reg, ctrl_reg, w_reg, tl_reg;
	logic [7:0] mem_reg [DATA_DEPTH];
	logic [2:0] edgeCnt_reg;
	logic [15:0] busyCnt_reg;
	logic devData_reg, devOeN_reg;

	function automatic logic [7:0] readFile(input logic [7:0] fa, input logic [7:0] al,
		input logic [7:0] ah, input logic [7:0] d, input logic [7:0] c, input logic [7:0] t);
		case (fa)
			FA_ADDR_LOW: readFile = al;
			FA_ADDR_HIGH: readFile = ah;
			FA_DATA: readFile = d;
			FA_CTRL: readFile = c;
			FA_TABLE_LATCH: readFile = t;
			default: readFile = 8'h00;
		endcase
	endfunction

	wire pgcS = clkSync_reg[1];
	wire datS = datSync_reg[1];
	wire fallEdge = pgcPrev_reg & ~pgcS;
	wire riseEdge = ~pgcPrev_reg & pgcS;
	wire frameEnd = fallEdge && (bitCnt_reg == 5'(FRAME_BITS - 1));
	wire [15:0] word = {datS, pay_reg[14:0]};
	wire exec = frameEnd && (cmd_reg == CMD_CORE);
	wire isMovlw = word[15:8] == OPC_MOVLW;
	wire isMovwf = word[15:8] == OPC_MOVWF;
	wire isMovfW = (word[15:10] == OPC_MOVF) && !word[9];
	wire isBsf = word[15:12] == OPC_BSF;
	wire isBcf = word[15:12] == OPC_BCF;
	wire [7:0] fa = word[7:0];
	wire [7:0] bitMask = 8'h01 << word[11:9];
	wire [7:0] fileNow = readFile(fa, addrLow_reg, addrHigh_reg, data_reg, ctrl_reg, tl_reg);
	wire wEn = exec && (isMovwf || isBsf || isBcf);
	wire [7:0] wVal = isMovwf ? w_reg : (isBsf ? (fileNow | bitMask) : (fileNow & ~bitMask));
	wire ctrlWr = wEn && fa == FA_CTRL;
	// start only with write enable already set
	wire wrSet = ctrlWr && wVal[CTRL_WR] && ctrl_reg[CTRL_WRITE_ENABLE_BIT] && state_reg == D_IDLE;
	wire rdPulse = ctrlWr && wVal[CTRL_RD];
	wire dataSpace = ctrl_reg[CTRL_PROG_SEL:CTRL_CFG_SEL] == 2'b00;
	// blank code reads ones, config reserved bits read zero
	wire [7:0] readByte = ctrl_reg[CTRL_CFG_SEL] ? (ERASED_BYTE & CFG_USED_MASK) :
		(ctrl_reg[CTRL_PROG_SEL] ? ERASED_BYTE : mem_reg[addrLow_reg]);
	wire commit = state_reg == D_WRITING && busyCnt_reg == 16'(WRITE_CYCLES - 1);
	wire [2:0] txIdx = 3'(bitCnt_reg - 5'(RX_FIRST_BIT));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clkSync_reg <= 2'h0;
			datSync_reg <= 2'h3;
			pgcPrev_reg <= 1'b0;
		end else begin
			clkSync_reg <= {clkSync_reg[0], link.progClk};
			datSync_reg <= {datSync_reg[0], link.pinLevel};
			pgcPrev_reg <= pgcS;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bitCnt_reg <= 5'h00;
			cmd_reg <= 4'h0;
			pay_reg <= 16'h0000;
		end else if (fallEdge) begin
			if (bitCnt_reg < 5'(CMD_BITS))
				cmd_reg[bitCnt_reg[1:0]] <= datS;
			else
				pay_reg[4'(bitCnt_reg - 5'(CMD_BITS))] <= datS;
			bitCnt_reg <= frameEnd ? 5'h00 : bitCnt_reg + 5'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addrLow_reg <= 8'h00;
			addrHigh_reg <= 8'h00;
			w_reg <= 8'h00;
			tl_reg <= 8'h00;
		end else begin
			if (wEn && fa == FA_ADDR_LOW)
				addrLow_reg <= wVal;
			if (wEn && fa == FA_ADDR_HIGH)
				addrHigh_reg <= wVal;
			if (wEn && fa == FA_TABLE_LATCH)
				tl_reg <= wVal;
			if (exec && isMovlw)
				w_reg <= word[7:0];
			else if (exec && isMovfW)
				w_reg <= fileNow;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			data_reg <= 8'h00;
		else if (wEn && fa == FA_DATA)
			data_reg <= wVal;
		else if (rdPulse)
			data_reg <= readByte;
	end

	// write-start bit cleared by hardware at the end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ctrl_reg <= CTRL_RESET;
		else if (ctrlWr) begin
			ctrl_reg[CTRL_PROG_SEL] <= wVal[CTRL_PROG_SEL];
			ctrl_reg[CTRL_CFG_SEL] <= wVal[CTRL_CFG_SEL];
			ctrl_reg[CTRL_WRITE_ENABLE_BIT] <= wVal[CTRL_WRITE_ENABLE_BIT];
			// a write ending in the cycle of a control write must still drop the start bit
			ctrl_reg[CTRL_WR] <= (ctrl_reg[CTRL_WR] & ~commit) | wrSet;
		end else if (commit)
			ctrl_reg[CTRL_WR] <= 1'b0;
	end

	// fourth falling edge after the start bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= D_IDLE;
			edgeCnt_reg <= 3'h0;
			busyCnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				D_IDLE: begin
					edgeCnt_reg <= 3'h0;
					busyCnt_reg <= 16'h0000;
					if (wrSet)
						state_reg <= D_ARMED;
				end
				D_ARMED: begin
					if (fallEdge) begin
						edgeCnt_reg <= edgeCnt_reg + 3'h1;
						if (edgeCnt_reg == 3'(WR_START_EDGE - 1))
							state_reg <= D_WRITING;
					end
				end
				D_WRITING: begin
					busyCnt_reg <= busyCnt_reg + 16'h0001;
					if (commit)
						state_reg <= D_IDLE;
				end
				default: state_reg <= D_IDLE;
			endcase
		end
	end

	// a byte write simply overwrites the cell, with no erase first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DATA_DEPTH; i++)
				mem_reg[i] <= ERASED_BYTE;
		end else if (commit && dataSpace)
			mem_reg[addrLow_reg] <= data_reg;
	end

	// table latch shifted out on the data pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			devData_reg <= 1'b1;
			devOeN_reg <= 1'b1;
			writeBusy <= 1'b0;
		end else begin
			writeBusy <= state_reg != D_IDLE;
			if (frameEnd)
				devOeN_reg <= 1'b1;
			else if (riseEdge && cmd_reg == CMD_SHIFT_OUT && bitCnt_reg >= 5'(RX_FIRST_BIT)) begin
				devData_reg <= tl_reg[txIdx];
				devOeN_reg <= 1'b0;
			end
		end
	end

	assign link.devData = devData_reg;
	assign link.devDataOeN = devOeN_reg;
endmodule // sdep_device

// ### hw/sdep_icsp_if.sv
// serial programming link: clock pin and shared data pin
`timescale 1ns/1ps
interface sdep_icsp_if;
	logic progClk;
	logic hostData;
	logic hostDataOeN;
	logic devData;
	logic devDataOeN;
	logic pinLevel;
	// weak pull-up when nobody drives
	assign pinLevel = !hostDataOeN ? hostData : (!devDataOeN ? devData : 1'b1);
	modport prog(output progClk, output hostData, output hostDataOeN, input pinLevel);
	modport dev(input progClk, input pinLevel, output devData, output devDataOeN);
endinterface

// ### hw/sdep_pkg.sv
// shared constants for the serial data memory programming link
package sdep_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	// link framing: 4 command bits then 16 payload bits, lsb first
	localparam int FRAME_BITS = 20;
	localparam int CMD_BITS = 4;
	localparam int RX_FIRST_BIT = 12;
	localparam logic [3:0] CMD_CORE = 4'h0;
	localparam logic [3:0] CMD_SHIFT_OUT = 4'h2;
	// core instruction opcodes
	localparam logic [7:0] OPC_MOVLW = 8'h0e;
	localparam logic [7:0] OPC_MOVWF = 8'h6e;
	localparam logic [5:0] OPC_MOVF = 6'h14;
	localparam logic [3:0] OPC_BSF = 4'h8;
	localparam logic [3:0] OPC_BCF = 4'h9;
	// file addresses
	localparam logic [7:0] FA_ADDR_LOW = 8'ha9;
	localparam logic [7:0] FA_ADDR_HIGH = 8'haa;
	localparam logic [7:0] FA_DATA = 8'ha8;
	localparam logic [7:0] FA_CTRL = 8'ha6;
	localparam logic [7:0] FA_TABLE_LATCH = 8'hf5;
	// control register bits
	localparam int CTRL_PROG_SEL = 7;
	localparam int CTRL_CFG_SEL = 6;
	localparam int CTRL_WRITE_ENABLE_BIT = 2;
	localparam int CTRL_WR = 1;
	localparam int CTRL_RD = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// fixed instruction words
	localparam logic [15:0] I_CLR_PROG = 16'h9ea6;
	localparam logic [15:0] I_CLR_CFG = 16'h9ca6;
	localparam logic [15:0] I_SET_WRITE_ENABLE_BIT = 16'h84a6;
	localparam logic [15:0] I_SET_WR = 16'h82a6;
	localparam logic [15:0] I_SET_RD = 16'h80a6;
	localparam logic [15:0] I_CTRL_TO_W = 16'h50a6;
	localparam logic [15:0] I_DATA_TO_W = 16'h50a8;
	localparam logic [15:0] I_W_TO_TL = 16'h6ef5;
	localparam logic [15:0] I_NOP = 16'h0000;
	localparam logic [15:0] I_CLR_WRITE_ENABLE_BIT = 16'h94a6;
	// memory
	localparam int DATA_DEPTH = 256;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] CFG_USED_MASK = 8'h3f;
	localparam logic [7:0] ADDR_HIGH_VALUE = 8'h00;
	// timing
	localparam int WR_START_EDGE = 4;
	localparam int WRITE_TIME_NS = 4000;
	localparam int WRITE_CYCLES = WRITE_TIME_NS * CLK_MHZ / 1000;
	localparam int DISCHARGE_HOLD_TIME_NS = 100_000;
	localparam int DISCHARGE_CYCLES = (DISCHARGE_HOLD_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int PGC_HALF_NS = 300;
	localparam int PGC_HALF_CYCLES = PGC_HALF_NS * CLK_MHZ / 1000;
	// programmer step indices
	localparam logic [3:0] W_POLL_FIRST = 4'd10;
	localparam logic [3:0] W_POLL_SHIFT = 4'd13;
	localparam logic [3:0] W_LAST = 4'd14;
	localparam logic [3:0] R_SHIFT = 4'd10;
	// user operation codes
	localparam logic [1:0] UOP_WRITE = 2'h0;
	localparam logic [1:0] UOP_VERIFY = 2'h1;
	localparam logic [1:0] UOP_BLANK = 2'h2;
endpackage

// ### hw/sdep_programmer.sv
// programmer end: sequences write, verify and blank check over the serial link
`timescale 1ns/1ps
module sdep_programmer
	import sdep_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	sdep_icsp_if.prog link,
	input wire logic reqValid,
	input wire logic [1:0] reqOp,
	input wire logic [7:0] reqAddr,
	input wire logic [7:0] reqData,
	output logic busy,
	output logic done,
	output logic pass,
	output logic [7:0] readData,
	output logic [7:0] failAddr
);
	typedef enum logic [3:0] {P_IDLE = 4'b0001, P_HIGH = 4'b0010, P_LOW = 4'b0100,
		P_DISCH = 4'b1000} sdep_pst_t;
	sdep_pst_t state_reg;
	logic [1:0] op_reg;
	logic [7:0] addr_reg, data_reg, rx_reg;
	logic [3:0] step_reg;
	logic [4:0] bit_reg;
	logic [15:0] phase_reg;
	logic [1:0] pinSync_reg;
	logic pgc_reg, out_reg, oeN_reg;

	// frame as sent: command nibble in the low bits, payload above, lsb first
	function automatic logic [19:0] stepWord(input logic [1:0] op, input logic [3:0] step,
		input logic [7:0] addr, input logic [7:0] data);
		logic [15:0] ins;
		logic [3:0] cmd;
		ins = I_NOP;
		cmd = CMD_CORE;
		case (step)
			4'd0: ins = I_CLR_PROG;
			4'd1: ins = I_CLR_CFG;
			4'd2: ins = {OPC_MOVLW, addr};
			4'd3: ins = {OPC_MOVWF, FA_ADDR_LOW};
			4'd4: ins = {OPC_MOVLW, ADDR_HIGH_VALUE};
			4'd5: ins = {OPC_MOVWF, FA_ADDR_HIGH};
			default: begin
				if (op == UOP_WRITE) begin
					case (step)
						4'd6: ins = {OPC_MOVLW, data};
						4'd7: ins = {OPC_MOVWF, FA_DATA};
						4'd8: ins = I_SET_WRITE_ENABLE_BIT;
						4'd9: ins = I_SET_WR;
						4'd10: ins = I_CTRL_TO_W;
						4'd11: ins = I_W_TO_TL;
						4'd13: cmd = CMD_SHIFT_OUT;
						4'd14: ins = I_CLR_WRITE_ENABLE_BIT;
						default: ins = I_NOP;
					endcase
				end else begin
					case (step)
						4'd6: ins = I_SET_RD;
						4'd7: ins = I_DATA_TO_W;
						4'd8: ins = I_W_TO_TL;
						4'd10: cmd = CMD_SHIFT_OUT;
						default: ins = I_NOP;
					endcase
				end
			end
		endcase
		stepWord = {ins, cmd};
	endfunction

	wire [19:0] frame = stepWord(op_reg, step_reg, addr_reg, data_reg);
	wire isShift = frame[3:0] == CMD_SHIFT_OUT;
	wire pinS = pinSync_reg[1];
	wire halfDone = phase_reg == 16'(PGC_HALF_CYCLES - 1);
	wire lastBit = bit_reg == 5'(FRAME_BITS - 1);
	wire rxBit = isShift && bit_reg >= 5'(RX_FIRST_BIT);
	wire frameDone = state_reg == P_LOW && halfDone && lastBit;
	wire [7:0] rxFinal = {pinS, rx_reg[7:1]};
	// blank expect data is all ones
	wire [7:0] expectByte = (op_reg == UOP_BLANK) ? ERASED_BYTE : data_reg;
	wire match = rxFinal == expectByte;
	wire writeOp = op_reg == UOP_WRITE;
	wire pollEnd = frameDone && writeOp && step_reg == W_POLL_SHIFT;
	wire readEnd = frameDone && !writeOp && step_reg == R_SHIFT;
	wire writeEnd = frameDone && writeOp && step_reg == W_LAST;
	// walk stops at last data byte
	wire lastAddr = addr_reg == 8'(DATA_DEPTH - 1);
	wire finish = writeEnd || (readEnd && (op_reg == UOP_VERIFY || !match || lastAddr));
	wire dischDone = state_reg == P_DISCH && phase_reg == 16'(DISCHARGE_CYCLES - 1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			pinSync_reg <= 2'h3;
		else
			pinSync_reg <= {pinSync_reg[0], link.pinLevel};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= P_IDLE;
			phase_reg <= 16'h0000;
			bit_reg <= 5'h00;
			step_reg <= 4'h0;
		end else begin
			case (state_reg)
				P_IDLE: begin
					phase_reg <= 16'h0000;
					bit_reg <= 5'h00;
					step_reg <= 4'h0;
					if (reqValid)
						state_reg <= P_HIGH;
				end
				P_HIGH: begin
					phase_reg <= halfDone ? 16'h0000 : phase_reg + 16'h0001;
					if (halfDone)
						state_reg <= P_LOW;
				end
				P_LOW: begin
					phase_reg <= halfDone ? 16'h0000 : phase_reg + 16'h0001;
					if (halfDone) begin
						bit_reg <= lastBit ? 5'h00 : bit_reg + 5'h01;
						state_reg <= P_HIGH;
						if (finish)
							state_reg <= P_IDLE;
						// loop while the start bit still reads set
						else if (pollEnd && rxFinal[CTRL_WR])
							step_reg <= W_POLL_FIRST;
						else if (pollEnd)
							state_reg <= P_DISCH;
						else if (readEnd)
							step_reg <= 4'h0;
						else if (lastBit)
							step_reg <= step_reg + 4'h1;
					end
				end
				P_DISCH: begin
					phase_reg <= dischDone ? 16'h0000 : phase_reg + 16'h0001;
					if (dischDone) begin
						step_reg <= W_LAST;
						state_reg <= P_HIGH;
					end
				end
				default: state_reg <= P_IDLE;
			endcase
		end
	end

	// blank check walks the data memory from address 0 up to the first non-blank byte, or to the last byte
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			op_reg <= UOP_WRITE;
			addr_reg <= 8'h00;
			data_reg <= 8'h00;
		end else if (state_reg == P_IDLE && reqValid) begin
			op_reg <= reqOp;
			addr_reg <= (reqOp == UOP_BLANK) ? 8'h00 : reqAddr;
			data_reg <= reqData;
		end else if (readEnd && op_reg == UOP_BLANK && match && !lastAddr)
			addr_reg <= addr_reg + 8'h01;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rx_reg <= 8'h00;
		else if (state_reg == P_LOW && halfDone && rxBit)
			rx_reg <= rxFinal;
	end

	// compare each byte as soon as it arrives
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			done <= 1'b0;
			pass <= 1'b0;
			readData <= 8'h00;
			failAddr <= 8'h00;
		end else begin
			busy <= !(state_reg == P_IDLE) && !finish;
			done <= finish;
			if (readEnd)
				readData <= rxFinal;
			if (writeEnd)
				pass <= 1'b1;
			else if (readEnd && (op_reg == UOP_VERIFY || !match || lastAddr))
				pass <= match;
			if (readEnd && !match)
				failAddr <= addr_reg;
		end
	end

	// bits driven at the start of each high phase, released for read-back
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pgc_reg <= 1'b0;
			out_reg <= 1'b0;
			oeN_reg <= 1'b1;
		end else begin
			pgc_reg <= state_reg == P_HIGH;
			if (state_reg == P_HIGH && phase_reg == 16'h0000) begin
				out_reg <= rxBit ? 1'b0 : frame[bit_reg];
				oeN_reg <= rxBit;
			end else if (state_reg == P_IDLE || state_reg == P_DISCH) begin
				out_reg <= 1'b0;
				oeN_reg <= 1'b0;
			end
		end
	end

	assign link.progClk = pgc_reg;
	assign link.hostData = out_reg;
	assign link.hostDataOeN = oeN_reg;
endmodule // sdep_programmer

// ### tb/sdep_props.sv
// concurrent checks on the serial programming link between the two ends
`timescale 1ns/1ps
module sdep_props
	import sdep_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic progClk,
	input wire logic hostData,
	input wire logic hostDataOeN,
	input wire logic devData,
	input wire logic devDataOeN,
	input wire logic pinLevel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic [11:0] clkLow_reg;
	logic [11:0] devDrive_reg;
	wire logic [11:0] clkLow_next;
	wire logic [11:0] devDrive_next;
	// saturate so a long discharge hold never wraps to a short count
	assign clkLow_next = progClk ? 12'h000 : clkLow_reg + {11'h000, clkLow_reg != 12'hfff};
	assign devDrive_next = devDataOeN ? 12'h000 : devDrive_reg + 12'h001;
	// reset counts as a long low phase so the first pulse is not flagged
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clkLow_reg <= 12'hfff;
			devDrive_reg <= 12'h000;
		end else begin
			clkLow_reg <= clkLow_next;
			devDrive_reg <= devDrive_next;
		end
	end

	sequence clkPulse;
		progClk [*6] ##1 !progClk;
	endsequence
	sequence devTurnOn;
		$fell(devDataOeN) ##0 progClk;
	endsequence

	a_clk_high_width: assert property ($rose(progClk) |-> clkPulse)
		else $error("link clock high phase has the wrong length");
	a_clk_low_width: assert property ($rose(progClk) |-> clkLow_reg >= 12'h006)
		else $error("link clock low phase too short");
	a_no_contention: assert property (hostDataOeN || devDataOeN)
		else $error("both ends drive the data pin");
	a_host_data_stable: assert property (
		$past(progClk) && !hostDataOeN && !$past(hostDataOeN) |-> $stable(hostData))
		else $error("programmer data moved outside the rising clock edge");
	a_dev_data_stable: assert property (
		!progClk && !$past(progClk) && !devDataOeN && !$past(devDataOeN) |-> $stable(pinLevel))
		else $error("device data moved during the low clock phase");
	a_dev_start_safe: assert property (devTurnOn |-> hostDataOeN)
		else $error("device drove the pin before the programmer let go");
	a_dev_release_low: assert property ($rose(devDataOeN) |-> !progClk)
		else $error("device released the pin outside the low clock phase");
	a_dev_drive_len: assert property (
		$rose(devDataOeN) |-> devDrive_reg inside {[12'h054:12'h060]})
		else $error("device drove the pin for the wrong number of bits");
	a_dev_data_edge: assert property ($changed(devData) |-> progClk)
		else $error("device data changed outside the high clock phase");
endmodule // sdep_props

// ### tb/serial_data_eeprom_programmer_bench.sv
// self-checking bench: programmer and device joined over the serial link
`timescale 1ns/1ps
module serial_data_eeprom_programmer_bench;
	import sdep_pkg::*;
	logic clk, nrst, reqValid, busy, done, pass, writeBusy, prevClk, wbPrev;
	logic [1:0] reqOp;
	logic [7:0] reqAddr, reqData, readData, failAddr, ra, rd;
	logic [19:0] frameCap, firstFrame;
	logic [7:0] mem [DATA_DEPTH];
	int n_mismatch, cmp_count, cycles, doneCnt, lowRun, maxLow, fallCnt, wbFalls, fall4Cyc;

	sdep_icsp_if link();
	sdep_programmer sdep_programmer_i(.clk(clk), .nrst(nrst), .link(link.prog),
		.reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData), .busy(busy),
		.done(done), .pass(pass), .readData(readData), .failAddr(failAddr));
	sdep_device sdep_device_i(.clk(clk), .nrst(nrst), .link(link.dev), .writeBusy(writeBusy));
	sdep_props sdep_props_i(.clk(clk), .nrst(nrst), .progClk(link.progClk),
		.hostData(link.hostData), .hostDataOeN(link.hostDataOeN), .devData(link.devData),
		.devDataOeN(link.devDataOeN), .pinLevel(link.pinLevel));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// sampled mid-cycle so every flop of the design has settled
	always @(negedge clk) begin
		cycles++;
		if (done === 1'b1) doneCnt++;
		lowRun = (link.progClk === 1'b0) ? lowRun + 1 : 0;
		if (lowRun > maxLow) maxLow = lowRun;
		if (writeBusy === 1'b1 && wbPrev !== 1'b1) wbFalls = 0;
		if (prevClk === 1'b1 && link.progClk === 1'b0) begin
			fallCnt++;
			frameCap = {link.pinLevel, frameCap[19:1]};
			if (fallCnt == FRAME_BITS) firstFrame = frameCap;
			if (writeBusy === 1'b1) wbFalls++;
			if (writeBusy === 1'b1 && wbFalls == WR_START_EDGE) fall4Cyc = cycles;
		end
		if (writeBusy === 1'b0 && wbPrev === 1'b1)
			check("write time", 1, (cycles - fall4Cyc) inside {[WRITE_CYCLES:WRITE_CYCLES + 6]});
		wbPrev = writeBusy;
		prevClk = link.progClk;
		if (cycles == 100000) begin
			n_mismatch++;
			$display("mismatch timeout expected done seen none");
			end_of_test();
		end
	end

	function automatic int first_used();
		for (int i = 0; i < DATA_DEPTH; i++) begin
			if (mem[i] !== ERASED_BYTE) return i;
		end
		return DATA_DEPTH;
	endfunction

	// poke raises a second request mid-operation, which must be ignored
	task automatic run_op(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d,
		input bit poke);
		int n;
		reqOp = op;
		reqAddr = a;
		reqData = d;
		reqValid = 1'b1;
		fallCnt = 0;
		maxLow = 0;
		lowRun = 0;
		@(posedge clk);
		#1 reqValid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(posedge clk);
			#1 n++;
			if (n == 1) check("busy", 1, busy);
			if (poke && n == 40) begin
				reqValid = 1'b1;
				reqOp = UOP_BLANK;
			end
			if (poke && n == 41) reqValid = 1'b0;
		end
		check("done", 1, done);
		check("busy at done", 0, busy);
		check("first frame", {I_CLR_PROG, CMD_CORE}, firstFrame);
	endtask

	task automatic do_write(input logic [7:0] a, input logic [7:0] d, input bit poke);
		run_op(UOP_WRITE, a, d, poke);
		mem[a] = d;
		check("discharge hold", 1, maxLow >= DISCHARGE_CYCLES);
	endtask

	task automatic do_verify(input logic [7:0] a, input logic [7:0] e);
		run_op(UOP_VERIFY, a, e, 1'b0);
		check("verify pass", mem[a] === e, pass);
		check("read byte", mem[a], readData);
		if (mem[a] !== e) check("fail addr", a, failAddr);
		check("no discharge", 1, maxLow < DISCHARGE_CYCLES);
	endtask

	task automatic do_blank();
		int fa;
		run_op(UOP_BLANK, 8'h00, 8'h00, 1'b0);
		fa = first_used();
		check("blank pass", fa == DATA_DEPTH, pass);
		check("blank addr", 8'(fa), failAddr);
		check("blank byte", mem[fa], readData);
	endtask

	initial begin
		nrst = 1'b0;
		reqValid = 1'b0;
		reqOp = 2'h0;
		reqAddr = 8'h00;
		reqData = 8'h00;
		{n_mismatch, cmp_count, cycles, doneCnt, lowRun, maxLow, fallCnt, wbFalls, fall4Cyc} = '0;
		{prevClk, wbPrev, frameCap, firstFrame} = '0;
		foreach (mem[i]) mem[i] = ERASED_BYTE;
		void'($urandom(32'h258ba48b));
		ra = 8'h03 + 8'($urandom_range(250));
		rd = 8'($urandom);
		repeat (8) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
		#1 check("idle link", 4'h1, {link.progClk, link.hostDataOeN, busy, link.devDataOeN});
		do_verify(ra, ERASED_BYTE);
		do_write(8'h02, 8'h0f, 1'b1);
		do_write(8'h02, 8'hf0, 1'b0);
		do_verify(8'h02, 8'hf0);
		do_verify(8'h02, 8'hf1);
		do_write(8'hff, 8'h00, 1'b0);
		do_verify(8'hff, 8'h00);
		do_write(ra, rd, 1'b0);
		do_verify(ra, rd);
		do_blank();
		repeat (20) @(posedge clk);
		#1 check("done count", 20'd10, 20'(doneCnt));
		end_of_test();
	end
endmodule // serial_data_eeprom_programmer_bench
